// ===== hw/tfid_bank.sv
/*
 * AXI4-Lite slave holding the read-only identification registers of a
 * trace funnel. Assumes a single clock and a master that holds payloads
 * until each handshake.
 */
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps

// Operation
// - secure non-invasive level reads 0b00
// - secure invasive level reads 0b00
// - non-secure non-invasive level reads 0b00
// - non-secure invasive level reads 0b00
// - priority scheme field reads programmable 0b0011
// - port count never zero or one
// - type sub-class reads 0b0001
// - type major class reads 0b0010
// - footprint field reads 0b0000, 4KB
// - low nibble returns continuation code
module tfid_bank
  import tfid_pkg::*;
#(
  parameter logic [3:0] PORT_COUNT = 4'h8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // Write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // Write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // Read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ****************************************
  // Register contents
  // ****************************************
  logic [31:0] auth_word;
  logic [31:0] cap_word;
  logic [31:0] type_word;
  logic [31:0] pid4_word;
  logic [3:0] port_total;

  assign port_total = (PORT_COUNT < TFID_PORTS_MIN) ? TFID_PORTS_MIN :
                      (PORT_COUNT > TFID_PORTS_MAX) ? TFID_PORTS_MAX : PORT_COUNT;

  assign auth_word = {24'h00_0000, TFID_LEVEL_ABSENT, TFID_LEVEL_ABSENT,
                      TFID_LEVEL_ABSENT, TFID_LEVEL_ABSENT};

  tfid_nib_pair u_cap (
    .hi_nib(TFID_SCHEME_PROG),
    .lo_nib(port_total),
    .word(cap_word)
  );

  tfid_nib_pair u_type (
    .hi_nib(TFID_SUB_ARB),
    .lo_nib(TFID_MAJOR_LINK),
    .word(type_word)
  );

  tfid_nib_pair u_pid4 (
    .hi_nib(TFID_SIZE_4KB),
    .lo_nib(TFID_CONT_CODE),
    .word(pid4_word)
  );

  // ****************************************
  // Write channel
  // ****************************************
  logic aw_seen_q, aw_seen_d;
  logic w_seen_q, w_seen_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic [11:0] awaddr_q, awaddr_d;
  logic [11:0] wr_addr;
  logic wr_hit;

  // Address and data may arrive in either order; hold off both while a response waits
  // Readies fall with the clock enable, so a frozen edge never passes for a handshake
  assign s_axi_awready = !aw_seen_q && !bvalid_q && clk_en;
  assign s_axi_wready = !w_seen_q && !bvalid_q && clk_en;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign wr_addr = aw_seen_q ? awaddr_q : s_axi_awaddr;
  assign wr_hit = (wr_addr[11:2] == TFID_AUTH_OFF[11:2]) || (wr_addr[11:2] == TFID_CAP_OFF[11:2]) ||
                  (wr_addr[11:2] == TFID_TYPE_OFF[11:2]) || (wr_addr[11:2] == TFID_PID4_OFF[11:2]);

  always_comb begin
    logic aw_now;
    logic w_now;
    aw_now = aw_seen_q || (s_axi_awvalid && s_axi_awready);
    w_now = w_seen_q || (s_axi_wvalid && s_axi_wready);
    aw_seen_d = aw_seen_q;
    w_seen_d = w_seen_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    awaddr_d = awaddr_q;
    if (s_axi_awvalid && s_axi_awready) begin
      awaddr_d = s_axi_awaddr;
    end
    if (bvalid_q) begin
      if (s_axi_bready) begin
        bvalid_d = 1'b0;
      end
    end else if (aw_now && w_now) begin
      bvalid_d = 1'b1;
      bresp_d = wr_hit ? TFID_RESP_OKAY : TFID_RESP_SLVERR;
      aw_seen_d = 1'b0;
      w_seen_d = 1'b0;
    end else begin
      aw_seen_d = aw_now;
      w_seen_d = w_now;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_seen_q <= 1'b0;
      w_seen_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= TFID_RESP_OKAY;
      awaddr_q <= 12'h000;
    end else if (clk_en) begin
      aw_seen_q <= aw_seen_d;
      w_seen_q <= w_seen_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      awaddr_q <= awaddr_d;
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic rd_mapped;

  // Same gating as the write side
  assign s_axi_arready = !rvalid_q && clk_en;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Decode kept apart from the read mux so the checks can name it
  assign rd_mapped = (s_axi_araddr[11:2] == TFID_AUTH_OFF[11:2]) ||
                     (s_axi_araddr[11:2] == TFID_CAP_OFF[11:2]) ||
                     (s_axi_araddr[11:2] == TFID_TYPE_OFF[11:2]) ||
                     (s_axi_araddr[11:2] == TFID_PID4_OFF[11:2]);

  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (rvalid_q) begin
      if (s_axi_rready) begin
        rvalid_d = 1'b0;
      end
    end else if (s_axi_arvalid) begin
      rvalid_d = 1'b1;
      rresp_d = TFID_RESP_OKAY;
      case (s_axi_araddr[11:2])
        TFID_AUTH_OFF[11:2]: rdata_d = auth_word;
        TFID_CAP_OFF[11:2]: rdata_d = cap_word;
        TFID_TYPE_OFF[11:2]: rdata_d = type_word;
        TFID_PID4_OFF[11:2]: rdata_d = pid4_word;
        default: begin
          rdata_d = TFID_ZERO_WORD;
          rresp_d = TFID_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= TFID_ZERO_WORD;
      rresp_q <= TFID_RESP_OKAY;
    end else if (clk_en) begin
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  // Read of the status word returns all levels absent
  auth_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] == TFID_AUTH_OFF[11:2])
      |=> (s_axi_rvalid && s_axi_rdata == 32'h0000_0000))
    else $error("status word not zero");

  secure_inv_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && $past(s_axi_araddr[11:2]) == TFID_AUTH_OFF[11:2]
      && $past(s_axi_arready)) |-> s_axi_rdata[5:4] == 2'h0)
    else $error("secure invasive level not zero");

  nonsec_levels_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] == TFID_AUTH_OFF[11:2])
      |=> s_axi_rdata[3:2] == 2'h0)
    else $error("non-secure non-invasive level not zero");

  nonsec_inv_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] == TFID_AUTH_OFF[11:2])
      |=> s_axi_rdata[1:0] == 2'h0)
    else $error("non-secure invasive level not zero");

  cap_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] == TFID_CAP_OFF[11:2])
      |=> (s_axi_rdata[7:4] == 4'h3 && s_axi_rdata[3:0] == port_total))
    else $error("capability word wrong");

  port_range_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] == TFID_CAP_OFF[11:2])
      |=> (s_axi_rdata[3:0] >= 4'h2 && s_axi_rdata[3:0] <= 4'h8))
    else $error("port count out of range");

  type_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] == TFID_TYPE_OFF[11:2])
      |=> (s_axi_rdata == 32'h0000_0012))
    else $error("type word wrong");

  pid4_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] == TFID_PID4_OFF[11:2])
      |=> (s_axi_rdata[31:4] == 28'h000_0000 && s_axi_rdata[3:0] == TFID_CONT_CODE))
    else $error("ident word wrong");

  write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) |=> s_axi_bvalid)
    else $error("write not answered");

  // ****************************************
  // Handshake checks
  // ****************************************
  // Read answer comes one cycle after the address is taken and stands until taken
  rd_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
    else $error("read not answered");

  rd_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)))
    else $error("read answer changed before taken");

  rd_release_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && s_axi_rvalid && s_axi_rready) |=> !s_axi_rvalid)
    else $error("read answer not released");

  // One read in flight: no new address while an answer waits
  rd_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer waits");

  // Write response stands until taken and blocks both request channels
  wr_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
    else $error("write response changed before taken");

  wr_release_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && s_axi_bvalid && s_axi_bready) |=> !s_axi_bvalid)
    else $error("write response not released");

  wr_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid |-> (!s_axi_awready && !s_axi_wready))
    else $error("write request taken while response waits");

  // A frozen edge must not look like a handshake to the master
  ready_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !clk_en |-> (!s_axi_arready && !s_axi_awready && !s_axi_wready))
    else $error("ready high while clock enable low");

  state_freeze_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !clk_en |=> ($stable(s_axi_rvalid) && $stable(s_axi_bvalid) && $stable(s_axi_rdata) &&
      $stable(s_axi_bresp)))
    else $error("state moved while clock enable low");

  // Reset is not gated by the clock enable
  reset_idle_a: assert property (@(posedge aclk)
    !aresetn |=> (!s_axi_rvalid && !s_axi_bvalid && s_axi_rdata == TFID_ZERO_WORD))
    else $error("answers not cleared by reset");

  // ****************************************
  // Response codes and fields
  // ****************************************
  mapped_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && s_axi_arvalid && s_axi_arready && rd_mapped) |=> s_axi_rresp == TFID_RESP_OKAY)
    else $error("mapped read not okay");

  stray_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && s_axi_arvalid && s_axi_arready && !rd_mapped)
      |=> (s_axi_rresp == TFID_RESP_SLVERR && s_axi_rdata == TFID_ZERO_WORD))
    else $error("stray read not refused");

  mapped_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && wr_hit)
      |=> s_axi_bresp == TFID_RESP_OKAY)
    else $error("mapped write not okay");

  stray_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !wr_hit)
      |=> s_axi_bresp == TFID_RESP_SLVERR)
    else $error("stray write not refused");

  major_class_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] == TFID_TYPE_OFF[11:2])
      |=> s_axi_rdata[3:0] == 4'h2)
    else $error("major class wrong");

  cap_upper_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] == TFID_CAP_OFF[11:2])
      |=> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("capability upper bits not zero");

  port_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] == TFID_CAP_OFF[11:2]
      && PORT_COUNT >= TFID_PORTS_MIN && PORT_COUNT <= TFID_PORTS_MAX) |=> s_axi_rdata[3:0] == PORT_COUNT)
    else $error("port count field wrong");

endmodule : tfid_bank

// ===== hw/tfid_nib_pair.sv
/*
 * Packs two nibbles into the low byte of a 32-bit word, upper bits zero.
 * Assumes constant or registered inputs.
 */
`timescale 1ns/100ps
module tfid_nib_pair
  import tfid_pkg::*;
(
  // Nibbles
  input wire logic [3:0] hi_nib,
  input wire logic [3:0] lo_nib,
  // Word
  output logic [31:0] word
);

  assign word = {24'h00_0000, hi_nib, lo_nib};

endmodule : tfid_nib_pair

// ===== hw/tfid_pkg.sv
/*
 * Constants of the trace funnel identification register bank.
 * Assumes a 32-bit AXI4-Lite register port; all registers read-only.
 */
package tfid_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [11:0] TFID_AUTH_OFF = 12'h0FB8;
  localparam logic [11:0] TFID_CAP_OFF = 12'h0FC8;
  localparam logic [11:0] TFID_TYPE_OFF = 12'h0FCC;
  localparam logic [11:0] TFID_PID4_OFF = 12'h0FD0;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int TFID_SEC_NONINV_LSB = 6;
  localparam int TFID_SEC_INV_LSB = 4;
  localparam int TFID_NS_NONINV_LSB = 2;
  localparam int TFID_NS_INV_LSB = 0;
  localparam int TFID_HI_NIB_LSB = 4;
  localparam int TFID_LO_NIB_LSB = 0;

  // ****************************************
  // Field values
  // ****************************************
  localparam logic [1:0] TFID_LEVEL_ABSENT = 2'h0;
  localparam logic [3:0] TFID_SCHEME_PROG = 4'h3;
  localparam logic [3:0] TFID_PORTS_MIN = 4'h2;
  localparam logic [3:0] TFID_PORTS_MAX = 4'h8;
  localparam logic [3:0] TFID_SUB_ARB = 4'h1;
  localparam logic [3:0] TFID_MAJOR_LINK = 4'h2;
  localparam logic [3:0] TFID_SIZE_4KB = 4'h0;
  // Arbitrary continuation code, not a real designer's value
  localparam logic [3:0] TFID_CONT_CODE = 4'h7;

  // ****************************************
  // Bus answers and reset values
  // ****************************************
  localparam logic [1:0] TFID_RESP_OKAY = 2'h0;
  localparam logic [1:0] TFID_RESP_SLVERR = 2'h2;
  localparam logic [31:0] TFID_ZERO_WORD = 32'h0000_0000;

endpackage : tfid_pkg

// ===== test/tb_top.sv
/*
 * Self-checking bench for the trace funnel identification register bank.
 * Assumes tfid_pkg and tfid_bank are compiled first; drives AXI4-Lite itself.
 */
`timescale 1ns/100ps
module tb_top;
  import tfid_pkg::*;
  localparam logic [3:0] PORTS = 4'h5;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic clk_en = 1'b1;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [11:0] regs [4] = '{TFID_AUTH_OFF, TFID_CAP_OFF, TFID_TYPE_OFF, TFID_PID4_OFF};
  int seed = 73;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int k;
  logic [33:0] got;
  logic [1:0] r;
  logic [11:0] a;

  tfid_bank #(.PORT_COUNT(PORTS)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  // ****************************************
  // Clock, timeout and verdict
  // ****************************************
  always #4 aclk = ~aclk;

  task close_out();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  // Well above the few hundred cycles the sequence needs
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      close_out();
    end
  end

  // ****************************************
  // Bus tasks and expectations
  // ****************************************
  task chk(input logic [33:0] seen, input logic [33:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t read back %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task rd(input logic [11:0] addr, output logic [33:0] res);
    araddr <= addr;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    res = {rresp, rdata};
    rready <= 1'b0;
  endtask : rd

  task wr(input logic [11:0] addr, input logic [31:0] d, output logic [1:0] resp);
    logic pa;
    logic pw;
    pa = 1'b1;
    pw = 1'b1;
    awaddr <= addr;
    wdata <= d;
    wstrb <= d[3:0];
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (pa && awready === 1'b1) begin
        pa = 1'b0;
        awvalid <= 1'b0;
      end
      if (pw && wready === 1'b1) begin
        pw = 1'b0;
        wvalid <= 1'b0;
      end
    end while (pa || pw);
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr

  // Low address bits select nothing, so they are dropped here
  function automatic logic [33:0] exp_rd(input logic [11:0] addr);
    case ({addr[11:2], 2'b00})
      TFID_AUTH_OFF: return {2'h0, 32'h0000_0000};
      TFID_CAP_OFF: return {2'h0, 24'h00_0000, 4'h3, PORTS};
      TFID_TYPE_OFF: return {2'h0, 24'h00_0000, 4'h1, 4'h2};
      TFID_PID4_OFF: return {2'h0, 24'h00_0000, 4'h0, TFID_CONT_CODE};
      default: return {2'h2, 32'h0000_0000};
    endcase
  endfunction : exp_rd

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (regs[i]) begin
      rd(regs[i], got);
      chk(got, exp_rd(regs[i]));
      wr(regs[i], $random(seed), r);
      chk({r, 32'h0000_0000}, {2'h0, 32'h0000_0000});
      rd(regs[i], got);
      chk(got, exp_rd(regs[i]));
    end
    wr(12'h004, 32'hFFFF_FFFF, r);
    chk({r, 32'h0000_0000}, {2'h2, 32'h0000_0000});
    // Random mix of mapped and stray addresses, with clock-enable gaps
    repeat (80) begin
      k = $random(seed);
      a = k[12] ? {regs[k[1:0]][11:2], k[3:2]} : k[15:4];
      if (k[20]) begin
        clk_en <= 1'b0;
        repeat (k[22:21] + 1) @(posedge aclk);
        clk_en <= 1'b1;
      end
      if (k[24]) begin
        wr(a, $random(seed), r);
        got = exp_rd(a);
        chk({r, 32'h0000_0000}, {got[33:32], 32'h0000_0000});
      end
      rd(a, got);
      chk(got, exp_rd(a));
    end
    // Second reset in mid-run
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(TFID_CAP_OFF, got);
    chk(got, exp_rd(TFID_CAP_OFF));
    close_out();
  end

endmodule : tb_top
